// ---- common/led_pwm_pkg.sv ----
// package: constants and carrier types for the led pwm channel select controller
// assumes a 125 MHz system clock; analog levels arrive as comparator flags
package led_pwm_pkg;

  // system clock
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned CLK_PERIOD_PS   = 8000;

  // switching frequency and duty ceiling
  localparam int unsigned SWITCH_FREQ_HZ  = 66_000;
  localparam int unsigned PERIOD_CYCLES   = CLK_HZ / SWITCH_FREQ_HZ;           // 1893
  localparam int unsigned DUTY_CEIL_PCT   = 79;
  localparam int unsigned DUTY_CEIL_CYCLES = (PERIOD_CYCLES * DUTY_CEIL_PCT) / 100; // rounds down

  // minimum on time and blanking, least times round up
  localparam int unsigned MIN_ON_PS       = 250_000;
  localparam int unsigned MIN_ON_CYCLES   = (MIN_ON_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned BLANK_PS        = 750_000;
  localparam int unsigned BLANK_CYCLES    = (BLANK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // short circuit rest and line debounce
  localparam int unsigned SC_REST_PERIODS = 3;
  localparam int unsigned DEBOUNCE_MS     = 19;
  localparam int unsigned DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;    // 2375000

  // widths
  localparam int unsigned PHASE_W         = 11;
  localparam int unsigned RAMP_W          = 8;
  localparam int unsigned DEB_W           = 22;
  localparam int unsigned REST_W          = 2;

  // reset values
  localparam logic        SELECT_A_RESET  = 1'b1;

  // supply state machine
  typedef enum logic [1:0] {
    SUPPLY_OFF,
    SUPPLY_RUN,
    SUPPLY_HALT
  } supply_state_t;

  // raw comparator flags from the analog front end
  typedef struct packed {
    logic supply_turn_on_level;   // supply above turn-on level
    logic supply_turn_off_level;  // supply above turn-off level
    logic line_on;                // line sense above rising level
    logic line_off;               // line sense above falling level
    logic cycle_limit_level;      // switch current above cycle limit
    logic short_circuit_level;    // switch current above short-circuit level
  } comp_flags_t;

  // string select pair
  typedef struct packed {
    logic string_a_select;
    logic string_b_select;
  } string_sel_t;

endpackage : led_pwm_pkg

// ---- hw/flag_sync.sv ----
// two-stage synchroniser for one asynchronous flag
// assumes the flag is a slow level from an analog comparator
`timescale 1ns/1ps
module flag_sync (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  // flag
  input  wire logic flag_in,
  output logic      flag_out
);

  logic meta_ff;

  // first stage feeds only the second
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_ff  <= 1'b0;
      flag_out <= 1'b0;
    end else begin
      meta_ff  <= flag_in;
      flag_out <= meta_ff;
    end
  end

endmodule : flag_sync

// ---- hw/led_pwm_channel_select_ctrl.sv ----
// led pwm channel select controller: gate drive pwm, supply lockout, line debounce, string select
// assumes comparator flags are asynchronous; reset_in is the logic reset level indication
//
// Contract
// RQ1: switching cycles repeat at about 66 kHz from an internal period counter.
// RQ2: each gate pulse ends no later than 79 percent of the period.
// RQ3: a started pulse stays high at least 250 ns before any turn-off; the code ends it at once when the state leaves SUPPLY_RUN.
// RQ4: the pulse ends when the internal ramp reaches the loop error level.
// RQ5: nothing runs until the supply turn-on flag shows the supply above the turn-on level; the code runs the period counter and line hysteresis from reset.
// RQ6: below the turn-off level the gate stops but string select and its timer keep running; the code clears the timer in SUPPLY_OFF.
// RQ7: below the logic reset level all control logic, string select included, is reset.
// RQ8: line sense uses hysteresis between the rising and falling comparator flags.
// RQ9: line absence must persist 19 ms before it counts as a switch-off event.
// RQ10: switch current is compared against a cycle limit and a higher short-circuit level.
// RQ11: a cycle limit trip holds the gate off for the rest of the cycle only.
// RQ12: a short-circuit trip suppresses pulses for three switching cycles.
// RQ13: a finished debounce stops the gate and swaps the selected string at the next power-up.
// RQ14: the current comparison is ignored for the first 750 ns of each cycle.
// RQ15: every comparator flag passes a two-stage synchroniser before use.
// RQ16: after full reset string a is selected and string b is off.
`timescale 1ns/1ps
module led_pwm_channel_select_ctrl
  import led_pwm_pkg::*;
(
  // clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       reset_in,
  // analog comparator flags
  input  wire led_pwm_pkg::comp_flags_t   comp_in,
  // loop error level from the error amplifier, full scale at ramp top
  input  wire logic [led_pwm_pkg::RAMP_W-1:0] error_level_in,
  // outputs
  output logic                            gate_drive_out,
  output led_pwm_pkg::string_sel_t        string_sel_out
);

  import led_pwm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // synchronised flags
  comp_flags_t   sync_flags;

  // RQ15 two-stage synchronisers
  for (genvar i = 0; i < $bits(comp_flags_t); i++) begin : g_sync
    flag_sync u_sync (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .flag_in  (comp_in[i]),
      .flag_out (sync_flags[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // supply state
  supply_state_t state_ff;
  supply_state_t nxt_state;
  logic          swap_pending_ff;
  logic          debounce_done;

  // RQ5 turn-on gating, RQ6 turn-off halt, RQ13 debounce halt
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SUPPLY_OFF: begin
        if (sync_flags.supply_turn_on_level) begin
          nxt_state = SUPPLY_RUN;
        end
      end
      SUPPLY_RUN: begin
        if (!sync_flags.supply_turn_off_level || debounce_done) begin
          nxt_state = SUPPLY_HALT;
        end
      end
      SUPPLY_HALT: begin
        if (!sync_flags.supply_turn_off_level) begin
          nxt_state = SUPPLY_OFF;
        end
      end
      default: nxt_state = SUPPLY_OFF;
    endcase
  end

  // RQ7 full reset of control logic
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_ff <= SUPPLY_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line detection with hysteresis and debounce
  logic              line_present_ff;
  logic [DEB_W-1:0]  deb_cnt_ff;

  // RQ8 hysteresis between rising and falling levels
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      line_present_ff <= 1'b0;
    end else if (sync_flags.line_on) begin
      line_present_ff <= 1'b1;
    end else if (!sync_flags.line_off) begin
      line_present_ff <= 1'b0;
    end
  end

  assign debounce_done = (deb_cnt_ff == DEB_W'(DEBOUNCE_CYCLES - 1)) && !line_present_ff;

  // RQ9 debounce timer, held at zero while the supply state is SUPPLY_OFF
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      deb_cnt_ff <= '0;
    end else if (line_present_ff || state_ff == SUPPLY_OFF) begin
      deb_cnt_ff <= '0;
    end else if (deb_cnt_ff != DEB_W'(DEBOUNCE_CYCLES - 1)) begin
      deb_cnt_ff <= deb_cnt_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // string select
  // RQ13 swap armed by completed debounce while running
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      swap_pending_ff <= 1'b0;
    end else if (state_ff == SUPPLY_RUN && debounce_done) begin
      swap_pending_ff <= 1'b1;
    end else if (state_ff == SUPPLY_OFF && sync_flags.supply_turn_on_level) begin
      swap_pending_ff <= 1'b0;
    end
  end

  // RQ16 string a after reset, RQ13 swap on power-up
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      string_sel_out.string_a_select <= SELECT_A_RESET;
      string_sel_out.string_b_select <= !SELECT_A_RESET;
    end else if (state_ff == SUPPLY_OFF && sync_flags.supply_turn_on_level && swap_pending_ff) begin
      string_sel_out.string_a_select <= !string_sel_out.string_a_select;
      string_sel_out.string_b_select <= !string_sel_out.string_b_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // switching period and ramp
  logic [PHASE_W-1:0] phase_ff;
  logic               period_start;
  logic [RAMP_W-1:0]  ramp;

  assign period_start = (phase_ff == PHASE_W'(PERIOD_CYCLES - 1));
  // ramp spans the full period in RAMP_W bits
  assign ramp = RAMP_W'((32'(phase_ff) << RAMP_W) / PERIOD_CYCLES);

  // RQ1 period counter
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      phase_ff <= '0;
    end else if (period_start) begin
      phase_ff <= '0;
    end else begin
      phase_ff <= phase_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // short-circuit rest
  logic [REST_W-1:0] rest_cnt_ff;
  logic              blanked;
  logic              sc_trip;
  logic              cl_trip;

  // RQ14 blanking window
  assign blanked = (phase_ff < PHASE_W'(BLANK_CYCLES));
  // RQ10 two current levels
  assign cl_trip = sync_flags.cycle_limit_level && !blanked;
  assign sc_trip = sync_flags.short_circuit_level && !blanked;

  // RQ12 three rest periods after a short-circuit trip
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rest_cnt_ff <= '0;
    end else if (sc_trip && gate_drive_out) begin
      rest_cnt_ff <= REST_W'(SC_REST_PERIODS);
    end else if (period_start && rest_cnt_ff != '0) begin
      rest_cnt_ff <= rest_cnt_ff - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gate drive
  logic min_on_met;
  logic turn_off;

  // RQ3 minimum on time
  assign min_on_met = (phase_ff >= PHASE_W'(MIN_ON_CYCLES - 1));
  // RQ4 ramp crossing, RQ11 cycle limit, RQ12 short circuit
  assign turn_off = min_on_met && ((ramp >= error_level_in) || cl_trip || sc_trip);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      gate_drive_out <= 1'b0;
    end else if (state_ff != SUPPLY_RUN || nxt_state != SUPPLY_RUN) begin
      // RQ6 gate stops on halt
      gate_drive_out <= 1'b0;
    end else if (period_start) begin
      // RQ11 resume next cycle, RQ12 unless resting
      // the rest count drops at this same edge, so only an empty count may start a pulse
      gate_drive_out <= (rest_cnt_ff == '0);
    end else if (phase_ff >= PHASE_W'(DUTY_CEIL_CYCLES - 1)) begin
      // RQ2 duty ceiling
      gate_drive_out <= 1'b0;
    end else if (turn_off) begin
      gate_drive_out <= 1'b0;
    end
  end

endmodule : led_pwm_channel_select_ctrl

// ---- bench/led_pwm_assertions.sv ----
// checker: pulse timing and string select relations at the controller ports
// assumes one clock domain and a bind onto the controller top
`timescale 1ns/1ps
module led_pwm_checker
  import led_pwm_pkg::*;
(
  // clock and reset
  input wire logic                            clk_in,
  input wire logic                            reset_in,
  // watched ports
  input wire led_pwm_pkg::comp_flags_t        comp_in,
  input wire logic [led_pwm_pkg::RAMP_W-1:0]  error_level_in,
  input wire logic                            gate_drive_out,
  input wire led_pwm_pkg::string_sel_t        string_sel_out
);
  int   hi_ff;
  int   gap_ff;
  int   lim;
  logic seen_ff;
  logic trip_ff;
  wire  sup = comp_in.supply_turn_off_level;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////////
  // high run length, rise spacing, current seen during the pulse
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      hi_ff   <= 0;
      gap_ff  <= 0;
      seen_ff <= 1'b0;
      trip_ff <= 1'b0;
    end else begin
      hi_ff   <= gate_drive_out ? hi_ff + 1 : 0;
      gap_ff  <= (gate_drive_out && hi_ff == 0) ? 1 : gap_ff + 1;
      seen_ff <= sup && (seen_ff || (gate_drive_out && hi_ff == 0));
      trip_ff <= gate_drive_out && (trip_ff || comp_in.cycle_limit_level || comp_in.short_circuit_level);
    end
  end
  // expected width for the present error level
  always_comb begin
    lim = (int'(error_level_in) * PERIOD_CYCLES + 255) / 256;
    lim = (lim < MIN_ON_CYCLES - 1) ? MIN_ON_CYCLES : lim + 1;
    if (lim > DUTY_CEIL_CYCLES) lim = DUTY_CEIL_CYCLES;
  end
  ////////////////////////////////////////////////////////////////
  duty_ceiling_a:
    assert property (hi_ff <= DUTY_CEIL_CYCLES) else $error("pulse longer than duty ceiling");
  min_on_time_a:
    assert property ($fell(gate_drive_out) && sup |-> hi_ff >= MIN_ON_CYCLES) else $error("pulse too short");
  ramp_cross_a:
    assert property ($fell(gate_drive_out) && sup && !trip_ff |-> hi_ff == lim) else $error("ramp crossing width");
  blank_window_a:
    assert property ($fell(gate_drive_out) && sup |-> hi_ff == lim || hi_ff > BLANK_CYCLES)
    else $error("pulse ended inside blanking");
  switch_period_a:
    assert property ($rose(gate_drive_out) && seen_ff |-> gap_ff == PERIOD_CYCLES || gap_ff == 4 * PERIOD_CYCLES)
    else $error("pulse spacing wrong");
  supply_stop_a:
    assert property (!sup [*6] |-> !gate_drive_out) else $error("gate on below turn-off level");
  select_onehot_a:
    assert property (string_sel_out.string_a_select != string_sel_out.string_b_select) else $error("select pair");
  reset_state_a:
    assert property ($fell(reset_in) |-> string_sel_out == 2'b10 && !gate_drive_out) else $error("state after reset");
endmodule : led_pwm_checker

bind led_pwm_channel_select_ctrl led_pwm_checker u_led_pwm_checker (.clk_in(clk_in), .reset_in(reset_in),
  .comp_in(comp_in), .error_level_in(error_level_in), .gate_drive_out(gate_drive_out),
  .string_sel_out(string_sel_out));

// ---- bench/led_front_end_model.sv ----
// model: analog comparators and power switch current in front of the controller
// assumes levels in tenths of a volt and a current sense ramp while the gate is on
`timescale 1ns/1ps
module led_front_end_model
  import led_pwm_pkg::*;
(
  // clock
  input  wire logic                      clk_in,
  // levels and gate
  input  wire logic                      gate_drive_in,
  input  wire logic [15:0]               vdd_dv_in,
  input  wire logic [15:0]               line_dv_in,
  input  wire logic [15:0]               slope_mv_in,
  // comparator flags
  output led_pwm_pkg::comp_flags_t       comp_out
);
  int on_cnt = 0;
  // switch current rises while the gate is on and collapses when off
  always @(posedge clk_in) on_cnt <= gate_drive_in ? on_cnt + 1 : 0;
  assign comp_out.supply_turn_on_level  = vdd_dv_in > 16'h0096;
  assign comp_out.supply_turn_off_level = vdd_dv_in > 16'h005f;
  assign comp_out.line_on               = line_dv_in > 16'h000f;
  assign comp_out.line_off              = line_dv_in > 16'h000a;
  assign comp_out.cycle_limit_level     = on_cnt * slope_mv_in > 800;
  assign comp_out.short_circuit_level   = on_cnt * slope_mv_in > 1150;
endmodule : led_front_end_model

// ---- bench/led_pwm_channel_select_ctrl_tb_top.sv ----
// testbench: pulse widths, current trips, supply lockout and reset of the controller
// assumes the front end model drives every comparator flag
`timescale 1ns/1ps
module led_pwm_channel_select_ctrl_tb_top;
  import led_pwm_pkg::*;
  typedef struct {logic [7:0] e; int w;} row_t;
  logic              clk_in   = 1'b0;
  logic              reset_in = 1'b1;
  logic [RAMP_W-1:0] err      = 8'h00;
  logic [15:0]       vdd      = 16'h0000;
  logic [15:0]       line     = 16'h0014;
  logic [15:0]       slope    = 16'h0000;
  logic              gate;
  comp_flags_t       comp;
  string_sel_t       sel;
  int                n_errors = 0;
  int                total_checks = 0;
  int                w;
  int                p;
  row_t rows[7] = '{'{8'h00, 32}, '{8'h04, 32}, '{8'h05, 38}, '{8'h80, 948}, '{8'hc9, 1488},
                    '{8'hca, 1495}, '{8'hff, 1495}};
  ////////////////////////////////////////////////////////////////
  // clock
  always #4 clk_in = ~clk_in;
  led_front_end_model u_led_front_end_model (.clk_in(clk_in), .gate_drive_in(gate), .vdd_dv_in(vdd),
    .line_dv_in(line), .slope_mv_in(slope), .comp_out(comp));
  led_pwm_channel_select_ctrl u_led_pwm_channel_select_ctrl (.clk_in(clk_in), .reset_in(reset_in),
    .comp_in(comp), .error_level_in(err), .gate_drive_out(gate), .string_sel_out(sel));
  ////////////////////////////////////////////////////////////////
  task check(input string name, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %0d seen %0d", name, exp, got);
    end
  endtask : check
  task end_of_test;
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task wait_gate(input logic v);
    for (int i = 0; i < 9000 && gate !== v; i++) @(negedge clk_in);
    if (gate !== v) begin
      n_errors++;
      end_of_test;
    end
  endtask : wait_gate
  // width of the next pulse into w, rise to rise into p
  task pulse;
    wait_gate(1'b0);
    wait_gate(1'b1);
    for (w = 0; gate === 1'b1 && w < 3000; w++) @(negedge clk_in);
    for (p = w; gate !== 1'b1 && p < 9000; p++) @(negedge clk_in);
  endtask : pulse
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    vdd      <= 16'h0078;
    @(negedge clk_in) check("select", sel, 2'b10);
    repeat (3 * PERIOD_CYCLES) @(negedge clk_in) check("gate_idle", gate, 1'b0);
    @(posedge clk_in) vdd <= 16'h00a0;
    foreach (rows[i]) begin
      wait_gate(1'b0);
      @(posedge clk_in) err <= rows[i].e;
      pulse;
      check("width", w, rows[i].w);
      check("period", p, PERIOD_CYCLES);
    end
    @(posedge clk_in) slope <= 16'h0004;
    pulse;
    check("limit_width", w inside {[202:206]}, 1'b1);
    check("limit_period", p, PERIOD_CYCLES);
    @(posedge clk_in) slope <= 16'h0014;
    pulse;
    check("short_width", w, BLANK_CYCLES + 1);
    check("short_period", p, 4 * PERIOD_CYCLES);
    @(posedge clk_in) slope <= 16'h0000;
    wait_gate(1'b1);
    @(posedge clk_in) vdd <= 16'h005a;
    repeat (8) @(negedge clk_in);
    repeat (PERIOD_CYCLES) @(negedge clk_in) check("gate_halt", gate, 1'b0);
    check("select_kept", sel, 2'b10);
    @(posedge clk_in) vdd <= 16'h00a0;
    pulse;
    check("restart_width", w, DUTY_CEIL_CYCLES);
    wait_gate(1'b1);
    @(posedge clk_in) reset_in <= 1'b1;
    @(negedge clk_in) check("reset_gate", gate, 1'b0);
    check("reset_select", sel, 2'b10);
    @(posedge clk_in) reset_in <= 1'b0;
    repeat (2) @(negedge clk_in) check("release_gate", gate, 1'b0);
    check("release_select", sel, 2'b10);
    end_of_test;
  end
endmodule : led_pwm_channel_select_ctrl_tb_top
